// ==== rtl/rtctw_pkg.sv ====
package rtctw_pkg;

  // ----------------------------------------------------------------
  // Address and register space
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h68;  // Address byte D0h without R/W bit
  localparam int         NUM_REGS   = 8;      // Clock and control bytes
  localparam int         PTR_W      = 3;      // Byte pointer width
  localparam logic [7:0] REG_RESET  = 8'h00;  // Byte value after reset
  localparam logic [3:0] ACK_SLOT   = 4'h8;   // Clock count after eight data bits
  localparam logic [3:0] DONE_SLOT  = 4'h9;   // Clock count after acknowledge bit

  // ----------------------------------------------------------------
  // Times in ns
  // ----------------------------------------------------------------
  localparam int SYS_NS  = 10;    // System clock period
  localparam int LINK_NS = 15;    // Link clock period
  localparam int FILT_NS = 50;    // Shortest pulse passed by filter
  localparam int HOLD_NS = 300;   // Output hold after clock fall
  localparam int TLOW_NS = 1300;  // Least clock low period
  localparam int TBUF_NS = 1300;  // Least bus free time

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int FILT_CYC = (FILT_NS + LINK_NS - 1) / LINK_NS;      // Filter samples
  localparam int HOLD_CYC = (HOLD_NS + LINK_NS - 1) / LINK_NS;      // Hold cycles
  localparam int QTR_CYC  = (TLOW_NS / 2 + SYS_NS - 1) / SYS_NS;    // Quarter bit
  localparam int BUF_CYC  = (TBUF_NS + SYS_NS - 1) / SYS_NS;        // Bus free cycles
  localparam int FILT_W   = $clog2(FILT_CYC + 1);                   // Filter counter width
  localparam int HOLD_W   = $clog2(HOLD_CYC + 1);                   // Hold counter width
  localparam int QTR_W    = $clog2(QTR_CYC + 1);                    // Quarter counter width
  localparam int BUF_W    = $clog2(BUF_CYC + 1);                    // Free counter width

  // ----------------------------------------------------------------
  // Master commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} rtctw_op_t;

endpackage : rtctw_pkg

// ==== rtl/rtctw_if.sv ====
`timescale 1ns/1ps

interface rtctw_if;

  // ----------------------------------------------------------------
  // Open-drain drivers of each party
  // ----------------------------------------------------------------
  logic scl_m_o;   // Master clock output level
  logic scl_m_oe;  // Master drives clock
  logic sda_m_o;   // Master data output level
  logic sda_m_oe;  // Master drives data
  logic sda_s_o;   // Slave data output level
  logic sda_s_oe;  // Slave drives data
  logic scl;       // Resolved clock line
  logic sda;       // Resolved data line

  // Pull-up resolution: any party driving low wins
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport host (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport dev  (output sda_s_o, sda_s_oe, input scl, sda);

endinterface : rtctw_if

// ==== rtl/rtctw_host.sv ====
`timescale 1ns/1ps

module rtctw_host import rtctw_pkg::*; (
  input  wire logic       clk_sys,    // System clock
  input  wire logic       rst,        // Synchronous reset
  rtctw_if.host           bus,        // Two-wire bus
  input  wire logic       cmd_valid,  // Command offered
  output logic            cmd_ready,  // Command taken
  input  wire rtctw_op_t  cmd_op,     // Command kind
  input  wire logic [7:0] cmd_data,   // Byte to write
  input  wire logic       cmd_ack,    // Acknowledge a read byte
  output logic            rsp_valid,  // Byte finished pulse
  output logic [7:0]      rsp_data,   // Byte seen on line
  output logic            rsp_nack    // Acknowledge bit was high
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum {H_IDLE, H_START, H_HOLD, H_BYTE, H_STOP} rtctw_hstate_t;

  rtctw_hstate_t    state_reg;     // Master state
  logic [1:0]       line_s1_reg;   // First sync stage {scl, sda}
  logic [1:0]       line_s2_reg;   // Second sync stage
  logic [QTR_W-1:0] qcnt_reg;      // Quarter bit timer
  logic [BUF_W-1:0] free_reg;      // Bus free timer
  logic [1:0]       phase_reg;     // Quarter within step
  logic [3:0]       bit_reg;       // Bit within byte
  logic [8:0]       sh_reg;        // Bits to send, acknowledge last
  logic [7:0]       rx_reg;        // Bits sampled
  logic             nack_reg;      // Sampled acknowledge
  logic             rsp_v_reg;     // Byte done pulse
  logic             scl_low_reg;   // Pull clock low
  logic             sda_low_reg;   // Pull data low
  logic             busy;          // Timed step running
  logic             qtick;         // Quarter elapsed
  logic             bus_free;      // Idle long enough
  logic             accept;        // Command handshake

  assign busy      = (state_reg == H_START) || (state_reg == H_STOP) || (state_reg == H_BYTE);
  assign qtick     = busy && (qcnt_reg == QTR_W'(QTR_CYC - 1));
  assign bus_free  = (free_reg == BUF_W'(BUF_CYC - 1));
  assign cmd_ready = ((state_reg == H_IDLE) && bus_free) || (state_reg == H_HOLD);
  assign accept    = cmd_valid && cmd_ready;

  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = scl_low_reg;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_low_reg;
  assign rsp_valid    = rsp_v_reg;
  assign rsp_data     = rx_reg;
  assign rsp_nack     = nack_reg;

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_s1_reg <= 2'h3;
      line_s2_reg <= 2'h3;
    end else begin
      line_s1_reg <= {bus.scl, bus.sda};
      line_s2_reg <= line_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // Quarter timer runs only in timed steps
  always_ff @(posedge clk_sys) begin
    if (rst || !busy || qtick) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + 1'b1;
    end
  end

  // Bus free timer: both lines high while idle
  always_ff @(posedge clk_sys) begin
    if (rst || (state_reg != H_IDLE) || (line_s2_reg != 2'h3)) begin
      free_reg <= '0;
    end else if (!bus_free) begin
      free_reg <= free_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg   <= H_IDLE;
      phase_reg   <= 2'h0;
      bit_reg     <= 4'h0;
      sh_reg      <= 9'h1ff;
      rx_reg      <= 8'h00;
      nack_reg    <= 1'b0;
      rsp_v_reg   <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      rsp_v_reg <= 1'b0;
      if (qtick) begin
        phase_reg <= phase_reg + 1'b1;
      end
      case (state_reg)
        H_IDLE: begin
          // Only a START leaves idle
          if (accept && (cmd_op == OP_START)) begin
            state_reg <= H_START;
            phase_reg <= 2'h0;
          end
        end
        H_HOLD: begin
          // Clock held low between steps
          if (accept) begin
            phase_reg <= 2'h0;
            bit_reg   <= 4'h0;
            case (cmd_op)
              OP_START: state_reg <= H_START;
              OP_STOP:  state_reg <= H_STOP;
              OP_WRITE: begin
                sh_reg    <= {cmd_data, 1'b1};
                state_reg <= H_BYTE;
              end
              default: begin
                sh_reg    <= {8'hff, ~cmd_ack};
                state_reg <= H_BYTE;
              end
            endcase
          end
        end
        H_START: begin
          // Release data, release clock, data low, clock low
          if (qtick) begin
            case (phase_reg)
              2'h0: sda_low_reg <= 1'b0;
              2'h1: scl_low_reg <= 1'b0;
              2'h2: sda_low_reg <= 1'b1;
              default: begin
                scl_low_reg <= 1'b1;
                state_reg   <= H_HOLD;
              end
            endcase
          end
        end
        H_STOP: begin
          // Data low, release clock, release data
          if (qtick) begin
            case (phase_reg)
              2'h0: sda_low_reg <= 1'b1;
              2'h1: scl_low_reg <= 1'b0;
              2'h2: sda_low_reg <= 1'b0;
              default: state_reg <= H_IDLE;
            endcase
          end
        end
        default: begin
          // One bit: set data, clock high, hold, sample and drop clock
          if (qtick) begin
            case (phase_reg)
              2'h0: sda_low_reg <= ~sh_reg[8];
              2'h1: scl_low_reg <= 1'b0;
              2'h2: ;
              default: begin
                scl_low_reg <= 1'b1;
                sh_reg      <= {sh_reg[7:0], 1'b1};
                if (bit_reg == ACK_SLOT) begin
                  nack_reg  <= line_s2_reg[0];
                  rsp_v_reg <= 1'b1;
                  state_reg <= H_HOLD;
                  bit_reg   <= 4'h0;
                end else begin
                  rx_reg  <= {rx_reg[6:0], line_s2_reg[0]};
                  bit_reg <= bit_reg + 1'b1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule : rtctw_host

// ==== rtl/rtctw_dev.sv ====
`timescale 1ns/1ps

module rtctw_dev import rtctw_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = SLAVE_ADDR  // Own bus address
) (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        rst,        // Synchronous reset
  input  wire logic        link_clk,   // Link sampling clock
  rtctw_if.dev             bus,        // Two-wire bus
  output logic             wr_strobe,  // Byte written pulse
  output logic [PTR_W-1:0] wr_index,   // Written byte location
  output logic [7:0]       wr_data     // Written byte value
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum {D_IDLE, D_ADDR, D_WORD, D_WDATA, D_RDATA, D_IGNORE} rtctw_dstate_t;

  rtctw_dstate_t     state_reg;                // Slave state
  logic              rst_l1_reg;               // Reset sync first stage
  logic              rst_link_reg;             // Reset sync second stage
  logic              rst_link;                 // Reset in link domain
  logic [1:0]        pin_s1_reg;               // Pin sync first stage
  logic [1:0]        pin_s2_reg;               // Pin sync second stage
  logic [1:0]        filt;                     // Filtered {scl, sda}
  logic              prev_scl_reg;             // Filtered clock, last cycle
  logic              prev_sda_reg;             // Filtered data, last cycle
  logic              scl_f;                    // Filtered clock
  logic              sda_f;                    // Filtered data
  logic              start_c;                  // START seen
  logic              stop_c;                   // STOP seen
  logic              rise_c;                   // Clock rising
  logic              fall_c;                   // Clock falling
  logic [3:0]        cnt_reg;                  // Clocks in current byte
  logic [7:0]        sh_reg;                   // Received bits
  logic [7:0]        tx_reg;                   // Bits left to send
  logic [PTR_W-1:0]  ptr_reg;                  // Byte pointer
  logic [PTR_W-1:0]  ptr_inc;                  // Next pointer
  logic              first_reg;                // First read byte pending
  logic              ack_seen_reg;             // Master acknowledged
  logic              pend_reg;                 // Drive level for next bit
  logic              drive_reg;                // Pull data low
  logic              hold_busy_reg;            // Hold delay running
  logic [HOLD_W-1:0] hold_cnt_reg;             // Hold delay counter
  logic [7:0]        mem_reg [0:NUM_REGS-1];   // Clock and control bytes
  logic              mem_we;                   // Data byte write
  logic              wr_tgl_reg;               // Write event toggle
  logic [PTR_W-1:0]  wr_idx_reg;               // Write index, link side
  logic [7:0]        wr_dat_reg;               // Write data, link side
  logic              wt_s1_reg;                // Toggle sync first stage
  logic              wt_s2_reg;                // Toggle sync second stage
  logic              wt_s3_reg;                // Toggle last value
  logic              strobe_reg;               // Write pulse, system side
  logic [PTR_W-1:0]  index_reg;                // Write index, system side
  logic [7:0]        data_reg;                 // Write data, system side

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  assign scl_f   = filt[1];
  assign sda_f   = filt[0];
  // Start needs clock and data high in the cycle before the data fall
  assign start_c = scl_f & prev_scl_reg & prev_sda_reg & ~sda_f;
  assign stop_c  = scl_f & prev_scl_reg & ~prev_sda_reg & sda_f;
  assign rise_c  = scl_f & ~prev_scl_reg;
  assign fall_c  = ~scl_f & prev_scl_reg;
  assign ptr_inc = ptr_reg + PTR_W'(1);
  assign mem_we  = fall_c && (state_reg == D_WDATA) && (cnt_reg == ACK_SLOT);

  // Open drain: only ever pulls low
  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = drive_reg;
  assign wr_strobe    = strobe_reg;
  assign wr_index     = index_reg;
  assign wr_data      = data_reg;

  // ----------------------------------------------------------------
  // Link reset and pin synchronisers
  // ----------------------------------------------------------------
  // Reset brought into link domain
  always_ff @(posedge link_clk) begin
    rst_l1_reg   <= rst;
    rst_link_reg <= rst_l1_reg;
  end

  assign rst_link = rst_link_reg;

  // Two flops on each pin
  always_ff @(posedge link_clk) begin
    if (rst_link) begin
      pin_s1_reg <= 2'h3;
      pin_s2_reg <= 2'h3;
    end else begin
      pin_s1_reg <= {bus.scl, bus.sda};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Spike filters
  // ----------------------------------------------------------------
  // New level taken after FILT_CYC agreeing samples
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [FILT_W-1:0] fcnt_reg;  // Agreeing samples
    logic              lvl_reg;   // Filtered level
    always_ff @(posedge link_clk) begin
      if (rst_link) begin
        fcnt_reg <= '0;
        lvl_reg  <= 1'b1;
      end else if (pin_s2_reg[g] == lvl_reg) begin
        fcnt_reg <= '0;
      end else if (fcnt_reg == FILT_W'(FILT_CYC - 1)) begin
        fcnt_reg <= '0;
        lvl_reg  <= pin_s2_reg[g];
      end else begin
        fcnt_reg <= fcnt_reg + 1'b1;
      end
    end
    assign filt[g] = lvl_reg;
  end

  // Previous filtered levels for edge detection
  always_ff @(posedge link_clk) begin
    if (rst_link) begin
      prev_scl_reg <= 1'b1;
      prev_sda_reg <= 1'b1;
    end else begin
      prev_scl_reg <= scl_f;
      prev_sda_reg <= sda_f;
    end
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (rst_link) begin
      state_reg    <= D_IDLE;
      cnt_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= '0;
      first_reg    <= 1'b0;
      ack_seen_reg <= 1'b0;
      pend_reg     <= 1'b0;
    end else if (start_c) begin
      // New or repeated START
      state_reg <= D_ADDR;
      cnt_reg   <= 4'h0;
      pend_reg  <= 1'b0;
    end else if (stop_c) begin
      // STOP closes any transfer
      state_reg <= D_IDLE;
      cnt_reg   <= 4'h0;
      pend_reg  <= 1'b0;
    end else if (rise_c) begin
      // Sample while clock high
      if ((state_reg != D_IDLE) && (state_reg != D_IGNORE) && (cnt_reg != DONE_SLOT)) begin
        if (cnt_reg == ACK_SLOT) begin
          ack_seen_reg <= ~sda_f;
        end else begin
          sh_reg <= {sh_reg[6:0], sda_f};
        end
        cnt_reg <= cnt_reg + 1'b1;
      end
    end else if (fall_c) begin
      // Decide next drive level on clock fall
      pend_reg <= 1'b0;
      if (cnt_reg == DONE_SLOT) begin
        cnt_reg <= 4'h0;
      end
      case (state_reg)
        D_ADDR: begin
          if (cnt_reg == ACK_SLOT) begin
            if (sh_reg[7:1] == DEV_ADDR) begin
              pend_reg  <= 1'b1;
              first_reg <= 1'b1;
              state_reg <= sh_reg[0] ? D_RDATA : D_WORD;
            end else begin
              state_reg <= D_IGNORE;
            end
          end
        end
        D_WORD: begin
          if (cnt_reg == ACK_SLOT) begin
            ptr_reg   <= sh_reg[PTR_W-1:0];
            pend_reg  <= 1'b1;
            state_reg <= D_WDATA;
          end
        end
        D_WDATA: begin
          if (cnt_reg == ACK_SLOT) begin
            ptr_reg  <= ptr_inc;
            pend_reg <= 1'b1;
          end
        end
        D_RDATA: begin
          if (cnt_reg == DONE_SLOT) begin
            if (first_reg) begin
              tx_reg    <= {mem_reg[ptr_reg][6:0], 1'b0};
              pend_reg  <= ~mem_reg[ptr_reg][7];
              first_reg <= 1'b0;
            end else if (ack_seen_reg) begin
              ptr_reg  <= ptr_inc;
              tx_reg   <= {mem_reg[ptr_inc][6:0], 1'b0};
              pend_reg <= ~mem_reg[ptr_inc][7];
            end else begin
              state_reg <= D_IGNORE;
            end
          end else if (cnt_reg != ACK_SLOT) begin
            pend_reg <= ~tx_reg[7];
            tx_reg   <= {tx_reg[6:0], 1'b0};
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output hold delay
  // ----------------------------------------------------------------
  // Line changes HOLD_CYC after the clock fall; START or STOP releases it at once
  always_ff @(posedge link_clk) begin
    if (rst_link || start_c || stop_c) begin
      drive_reg     <= 1'b0;
      hold_busy_reg <= 1'b0;
      hold_cnt_reg  <= '0;
    end else if (fall_c) begin
      hold_busy_reg <= 1'b1;
      hold_cnt_reg  <= '0;
    end else if (hold_busy_reg) begin
      if (hold_cnt_reg == HOLD_W'(HOLD_CYC - 1)) begin
        drive_reg     <= pend_reg;
        hold_busy_reg <= 1'b0;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte store and write event
  // ----------------------------------------------------------------
  // Eight locations, written by data bytes
  always_ff @(posedge link_clk) begin
    if (rst_link) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_reg[i] <= REG_RESET;
      end
    end else if (mem_we) begin
      mem_reg[ptr_reg] <= sh_reg;
    end
  end

  // Toggle marks each write; index and data held until next
  always_ff @(posedge link_clk) begin
    if (rst_link) begin
      wr_tgl_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_dat_reg <= 8'h00;
    end else if (mem_we) begin
      wr_tgl_reg <= ~wr_tgl_reg;
      wr_idx_reg <= ptr_reg;
      wr_dat_reg <= sh_reg;
    end
  end

  // ----------------------------------------------------------------
  // System side of write event
  // ----------------------------------------------------------------
  // Toggle synchroniser and pulse with captured word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wt_s1_reg  <= 1'b0;
      wt_s2_reg  <= 1'b0;
      wt_s3_reg  <= 1'b0;
      strobe_reg <= 1'b0;
      index_reg  <= '0;
      data_reg   <= 8'h00;
    end else begin
      wt_s1_reg  <= wr_tgl_reg;
      wt_s2_reg  <= wt_s1_reg;
      wt_s3_reg  <= wt_s2_reg;
      strobe_reg <= wt_s2_reg ^ wt_s3_reg;
      if (wt_s2_reg ^ wt_s3_reg) begin
        index_reg <= wr_idx_reg;
        data_reg  <= wr_dat_reg;
      end
    end
  end

endmodule : rtctw_dev

// ==== verification/rtctw_properties.sv ====
`timescale 1ns/1ps

// --------------------------------------------------------
// Line-level checks beside the two-wire link
// --------------------------------------------------------
module rtctw_properties (
  input wire logic clk_sys,   // System clock
  input wire logic rst,       // Synchronous reset
  input wire logic scl,       // Resolved clock line
  input wire logic sda,       // Resolved data line
  input wire logic scl_m_oe,  // Master pulls clock
  input wire logic sda_m_oe,  // Master pulls data
  input wire logic sda_s_oe   // Slave pulls data
);
  logic       scl_reg;  // Clock level one cycle back
  logic [6:0] cnt_reg;  // Cycles since last clock edge

  // Saturating age of the clock level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_reg <= 1'h1;
      cnt_reg <= 7'h00;
    end else begin
      scl_reg <= scl;
      cnt_reg <= (scl != scl_reg) ? 7'h00 : cnt_reg + {6'h00, cnt_reg != 7'h7f};
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_idle_lines_high: assert property (!scl_m_oe && !sda_m_oe && !sda_s_oe |-> scl && sda)
    else $error("released lines not high");
  chk_dev_drive_low: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("slave drive began with clock high");
  chk_dev_high_stable: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data moved with clock high");
  chk_dev_hold_time: assert property ($changed(sda_s_oe) |-> !scl && cnt_reg >= 7'h1d)
    else $error("slave data changed too soon after clock fall");
  chk_mst_hold_time: assert property ($changed(sda_m_oe) && !scl |-> cnt_reg >= 7'h1d)
    else $error("master data changed too soon after clock fall");
  chk_start_from_idle: assert property ($rose(sda_m_oe) && scl |-> $past(sda) && $past(scl) && !sda_s_oe)
    else $error("start without free data line");
  chk_stop_line_rise: assert property ($fell(sda_m_oe) && scl |-> sda)
    else $error("stop blocked by slave drive");
  chk_clock_high_len: assert property ($fell(scl) |-> cnt_reg >= 7'h3b)
    else $error("clock high period too short");
endmodule : rtctw_properties

// ==== verification/rtc_two_wire_slave_port_tb.sv ====
`timescale 1ns/1ps

module rtc_two_wire_slave_port_tb import rtctw_pkg::*;;
  logic             clk_sys = 1'h0;    // System clock
  logic             link_clk = 1'h0;   // Link sampling clock
  logic             rst = 1'h1;        // Reset
  logic             cmd_valid = 1'h0;  // Command offered
  logic             cmd_ack = 1'h0;    // Master acks read byte
  rtctw_op_t        cmd_op = OP_START; // Command kind
  logic [7:0]       cmd_data = 8'h00;  // Byte to send
  logic             cmd_ready, rsp_valid, rsp_nack, wr_strobe;
  logic [7:0]       rsp_data, wr_data;
  logic [PTR_W-1:0] wr_index;
  int               failures = 0, n_checks = 0;
  int               n_pulses = 0;      // Rises seen on the clock line
  logic [10:0]      wr_q[$];           // Written location and byte

  always #5 clk_sys = ~clk_sys;
  always #7.5 link_clk = ~link_clk;

  rtctw_if rtctw_if_i ();
  rtctw_host rtctw_host_i (.clk_sys(clk_sys), .rst(rst), .bus(rtctw_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  rtctw_dev rtctw_dev_i (.clk_sys(clk_sys), .rst(rst), .link_clk(link_clk), .bus(rtctw_if_i),
    .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data));
  rtctw_properties rtctw_properties_i (.clk_sys(clk_sys), .rst(rst), .scl(rtctw_if_i.scl),
    .sda(rtctw_if_i.sda), .scl_m_oe(rtctw_if_i.scl_m_oe), .sda_m_oe(rtctw_if_i.sda_m_oe),
    .sda_s_oe(rtctw_if_i.sda_s_oe));

  // Log every byte the device stores
  always @(negedge clk_sys) begin
    if (wr_strobe === 1'h1) wr_q.push_back({wr_index, wr_data});
  end

  // Count clock pulses that the master gives on the line
  always @(posedge rtctw_if_i.scl) begin
    n_pulses++;
  end

  task automatic chk(logic [10:0] got, logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One host command; byte commands wait for the byte to finish
  task automatic op(rtctw_op_t k, logic [7:0] d, logic a);
    int p0;  // Pulse count when the command is taken
    @(negedge clk_sys);
    cmd_op = k;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1) @(negedge clk_sys);
    p0 = n_pulses;
    // Taken at the rising edge between; drop the request off that edge
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    if (k == OP_WRITE || k == OP_READ) begin
      while (rsp_valid !== 1'h1) @(negedge clk_sys);
      chk(11'(n_pulses - p0), 11'h009);
    end
  endtask : op

  task automatic wb(logic [7:0] d, logic nk);
    op(OP_WRITE, d, 1'h0);
    chk({10'h000, rsp_nack}, {10'h000, nk});
  endtask : wb

  task automatic rb(logic [7:0] d, logic a);
    op(OP_READ, 8'h00, a);
    chk({3'h0, rsp_data}, {3'h0, d});
  endtask : rb

  // Three bytes from location 6 wrap past the control byte
  task automatic t_write();
    op(OP_START, 8'h00, 1'h0);
    wb(8'hd0, 1'h0);
    wb(8'h06, 1'h0);
    wb(8'ha5, 1'h0);
    wb(8'h3c, 1'h0);
    wb(8'h81, 1'h0);
    op(OP_STOP, 8'h00, 1'h0);
    chk(11'(wr_q.size()), 11'h003);
    chk(wr_q[0], {3'h6, 8'ha5});
    chk(wr_q[1], {3'h7, 8'h3c});
    chk(wr_q[2], {3'h0, 8'h81});
  endtask : t_write

  // Pointer set, repeated start, read back, last byte not acked
  task automatic t_read();
    op(OP_START, 8'h00, 1'h0);
    wb(8'hd0, 1'h0);
    wb(8'h06, 1'h0);
    op(OP_START, 8'h00, 1'h0);
    wb(8'hd1, 1'h0);
    rb(8'ha5, 1'h1);
    rb(8'h3c, 1'h1);
    rb(8'h81, 1'h0);
    op(OP_STOP, 8'h00, 1'h0);
  endtask : t_read

  // Foreign address ignored until the next start
  task automatic t_wrong();
    op(OP_START, 8'h00, 1'h0);
    wb(8'ha0, 1'h1);
    wb(8'h55, 1'h1);
    op(OP_START, 8'h00, 1'h0);
    wb(8'hd1, 1'h0);
    rb(8'h81, 1'h0);
    op(OP_STOP, 8'h00, 1'h0);
    chk(11'(wr_q.size()), 11'h003);
  endtask : t_wrong

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'h0;
    t_write();
    t_read();
    t_wrong();
    end_of_test();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule : rtc_two_wire_slave_port_tb
